// ===== shared/dtm_pkg.sv
package dtm_pkg;

  localparam int CA_W  = 6;
  localparam int DQ_W  = 8;
  localparam int TMR_W = 16;

  // controller clock and the divider that makes the link clock
  localparam int CLK_PS   = 20000;
  localparam int LINK_DIV = 2;
  localparam int CK_PS    = CLK_PS * LINK_DIV;
  localparam int SYNC_CLK = 4;

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : imax

  function automatic int up_clk(input int ps);
    return (ps + CLK_PS - 1) / CLK_PS;
  endfunction : up_clk

  function automatic int up_ck(input int ps);
    return imax(1, (ps + CK_PS - 1) / CK_PS);
  endfunction : up_ck

  function automatic int dn_ck(input int ps);
    return imax(1, ps / CK_PS);
  endfunction : dn_ck

  // times as printed, in ps, or in link clock cycles for the NCK ones
  localparam int HI_ON_PS      = 200000;
  localparam int HI_OFF_PS     = 100000;
  localparam int ADR_PS        = 20000;
  localparam int STRB_HOLD_PS  = 10000;
  localparam int ENTRY_PS      = 250000;
  localparam int VREF_SHORT_PS = 80000;
  localparam int VREF_LONG_PS  = 250000;
  localparam int XP_PS         = 7500;
  localparam int XP_NCK        = 5;
  localparam int PSTCS_PS      = 7500;
  localparam int PSTCS_NCK     = 5;
  localparam int CKELCK_PS     = 5000;
  localparam int CKELCK_NCK    = 5;
  localparam int SEL_STRB_NCK  = 2;
  localparam int STRB_REL_PS   = 10000;
  localparam int CKCKEH_PS     = 1750;
  localparam int CKCKEH_NCK    = 3;
  localparam int DQZ_PS        = 1500;
  localparam int ODT_PS        = 20000;
  localparam int WL_DQS_EN_NCK = 20;
  localparam int WL_PRE_NCK    = 20;
  localparam int WL_FIRST_NCK  = 40;
  localparam int WLO_PS        = 115000;

  // controller waits, in clk cycles
  localparam logic [TMR_W-1:0] C_STRB_HOLD = TMR_W'(up_clk(STRB_HOLD_PS));
  localparam logic [TMR_W-1:0] C_ENTRY     = TMR_W'(imax(imax(up_clk(ENTRY_PS),
      2 * LINK_DIV + imax(up_clk(XP_PS), XP_NCK * LINK_DIV)),
      imax(up_clk(CKELCK_PS), CKELCK_NCK * LINK_DIV)));
  localparam logic [TMR_W-1:0] C_SEL_STRB  = TMR_W'(SEL_STRB_NCK * LINK_DIV);
  localparam logic [TMR_W-1:0] C_CACD      = TMR_W'(LINK_DIV * ((ADR_PS + CK_PS - 1) / CK_PS));
  localparam logic [TMR_W-1:0] C_CA_RES    = TMR_W'(imax(C_CACD, LINK_DIV + SYNC_CLK));
  localparam logic [TMR_W-1:0] C_HOLD      = TMR_W'(imax(imax(up_clk(PSTCS_PS),
      PSTCS_NCK * LINK_DIV), imax(up_clk(CKCKEH_PS), CKCKEH_NCK * LINK_DIV)));
  localparam logic [TMR_W-1:0] C_STRB_REL  = TMR_W'(up_clk(STRB_REL_PS));
  localparam logic [TMR_W-1:0] C_WL_EN     = TMR_W'(WL_DQS_EN_NCK * LINK_DIV);
  localparam logic [TMR_W-1:0] C_WL_PRE    = TMR_W'(imax(WL_PRE_NCK,
      WL_FIRST_NCK - WL_DQS_EN_NCK) * LINK_DIV);
  localparam logic [TMR_W-1:0] C_WL_RES    = TMR_W'(up_clk(WLO_PS) + SYNC_CLK);

  // device waits, in link clock cycles
  localparam logic [TMR_W-1:0] D_HI_ON      = TMR_W'(dn_ck(HI_ON_PS));
  localparam logic [TMR_W-1:0] D_HI_OFF     = TMR_W'(dn_ck(HI_OFF_PS));
  localparam logic [TMR_W-1:0] D_VREF_SHORT = TMR_W'(dn_ck(VREF_SHORT_PS));
  localparam logic [TMR_W-1:0] D_VREF_LONG  = TMR_W'(dn_ck(VREF_LONG_PS));
  localparam logic [TMR_W-1:0] D_CACD       = TMR_W'((ADR_PS + CK_PS - 1) / CK_PS);
  localparam logic [TMR_W-1:0] D_DQZ        = TMR_W'(up_ck(DQZ_PS));
  localparam logic [TMR_W-1:0] D_ODT        = TMR_W'(up_ck(ODT_PS));

endpackage : dtm_pkg

// ===== shared/dtm_link_if.sv
`timescale 1ns/10ps
interface dtm_link_if;
  import dtm_pkg::*;
  logic            ck;
  logic            cke;
  logic            cs;
  logic [CA_W-1:0] ca;
  logic            ca_mode;
  logic            wl_mode;
  logic            dqs_t;
  logic            dqs_c;
  logic            dqs_oe;
  logic [DQ_W-1:0] dq;
  logic            dq_oe;

  modport ctrl (output ck, cke, cs, ca, ca_mode, wl_mode, dqs_t, dqs_c, dqs_oe,
                input dq, dq_oe);
  modport dev  (input ck, cke, cs, ca, ca_mode, wl_mode, dqs_t, dqs_c, dqs_oe,
                output dq, dq_oe);
endinterface : dtm_link_if

// ===== rtl/dtm_timer.sv
`timescale 1ns/10ps
module dtm_timer (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      load,
  input  wire logic [dtm_pkg::TMR_W-1:0] value,
  output logic                           zero
);
  import dtm_pkg::*;
  logic [TMR_W-1:0] count_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      count_ff <= '0;
    end else if (load) begin
      count_ff <= value;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - TMR_W'(1);
    end
  end

  assign zero = (count_ff == '0);
endmodule : dtm_timer

// ===== rtl/dtm_dev_end.sv
`timescale 1ns/10ps
module dtm_dev_end (
  dtm_link_if.dev                 link,
  input  wire logic               reset,
  input  wire logic               hi_current_req,
  output logic                    hi_current_on,
  output logic [dtm_pkg::CA_W-1:0] vref_code,
  output logic                    vref_settled,
  output logic                    odt_on
);
  import dtm_pkg::*;
  logic               rst_s1_ff, rst_ff;
  logic               hi_s1_ff, hi_s2_ff;
  logic [TMR_W-1:0]   vref_cnt_ff, sp_cnt_ff, dqz_cnt_ff, odt_cnt_ff;
  logic [CA_W-1:0]    samp_ff, vref_ff;
  logic               pend_ff, dqs_prev_ff, cke_prev_ff, odt_tgt_ff;
  logic [DQ_W-1:0]    dq_ff;
  logic               dq_oe_ff, settled_ff, odt_ff;
  logic               wl_cap_ff, wl_s1_ff;
  logic               train, cs_hit, strobe_rise;

  assign train       = link.ca_mode & ~link.cke;
  assign cs_hit      = train & link.cs;
  assign strobe_rise = link.dqs_oe & link.dqs_t & ~dqs_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // reset arrives from the controller domain
  always_ff @(posedge link.ck) begin
    rst_s1_ff <= reset;
    rst_ff    <= rst_s1_ff;
  end

  always_ff @(posedge link.ck) begin
    if (rst_ff) begin
      dqs_prev_ff <= 1'b0;
      cke_prev_ff <= 1'b1;
    end else begin
      dqs_prev_ff <= link.dqs_t;
      cke_prev_ff <= link.cke;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // high current mode follows the second synchroniser stage: both limits are
  // maxima, and the two stages already use up to 80 ns of the 100 ns budget
  always_ff @(posedge link.ck) begin
    hi_s1_ff <= hi_current_req;
    hi_s2_ff <= hi_s1_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference voltage step on each strobe rise while training
  always_ff @(posedge link.ck) begin
    if (rst_ff) begin
      vref_ff     <= '0;
      vref_cnt_ff <= '0;
      settled_ff  <= 1'b1;
    end else if (train && strobe_rise) begin
      vref_ff     <= samp_ff;
      settled_ff  <= 1'b0;
      // one bit wider so that the ends of the range are not one step apart
      if ({1'b0, samp_ff} == {1'b0, vref_ff} + (CA_W+1)'(1)
          || {1'b0, vref_ff} == {1'b0, samp_ff} + (CA_W+1)'(1)
          || samp_ff == vref_ff) begin
        vref_cnt_ff <= D_VREF_SHORT - TMR_W'(1);
      end else begin
        vref_cnt_ff <= D_VREF_LONG - TMR_W'(1);
      end
    end else if (vref_cnt_ff != '0) begin
      vref_cnt_ff <= vref_cnt_ff - TMR_W'(1);
    end else begin
      settled_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // training samples: a sample overwritten before its spacing ran out is lost
  always_ff @(posedge link.ck) begin
    if (rst_ff) begin
      samp_ff   <= '0;
      sp_cnt_ff <= '0;
      pend_ff   <= 1'b0;
    end else if (cs_hit) begin
      samp_ff   <= link.ca;
      sp_cnt_ff <= D_CACD - TMR_W'(1);
      pend_ff   <= 1'b1;
    end else if (sp_cnt_ff != '0) begin
      sp_cnt_ff <= sp_cnt_ff - TMR_W'(1);
    end else begin
      pend_ff <= 1'b0;
    end
  end

  // second stage of the leveling synchroniser is the data register itself
  always_ff @(posedge link.ck) begin
    if (rst_ff) begin
      dq_ff <= '0;
    end else if (link.wl_mode) begin
      dq_ff <= {{(DQ_W-1){1'b0}}, wl_s1_ff};
    end else if (pend_ff && sp_cnt_ff == '0) begin
      dq_ff <= {{(DQ_W-CA_W){1'b0}}, samp_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data drive at training entry and in leveling, release at training exit
  always_ff @(posedge link.ck) begin
    if (rst_ff) begin
      dq_oe_ff   <= 1'b0;
      dqz_cnt_ff <= '0;
    end else if (link.wl_mode || (train && cke_prev_ff)) begin
      dq_oe_ff   <= 1'b1;
      dqz_cnt_ff <= '0;
    end else if (link.ca_mode && link.cke && !cke_prev_ff) begin
      dqz_cnt_ff <= D_DQZ;
    end else if (dqz_cnt_ff > TMR_W'(1)) begin
      dqz_cnt_ff <= dqz_cnt_ff - TMR_W'(1);
    end else if (dqz_cnt_ff == TMR_W'(1) || !link.ca_mode) begin
      dqz_cnt_ff <= '0;
      dq_oe_ff   <= 1'b0;
    end
  end

  // termination follows inverted clock-enable during training, delayed
  always_ff @(posedge link.ck) begin
    if (rst_ff) begin
      odt_tgt_ff <= 1'b0;
      odt_cnt_ff <= '0;
      odt_ff     <= 1'b0;
    end else if (train != odt_tgt_ff) begin
      odt_tgt_ff <= train;
      odt_cnt_ff <= D_ODT;
    end else if (odt_cnt_ff > TMR_W'(1)) begin
      odt_cnt_ff <= odt_cnt_ff - TMR_W'(1);
    end else begin
      odt_cnt_ff <= '0;
      odt_ff     <= odt_tgt_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // leveling: the strobe samples the clock level in its own domain
  always_ff @(posedge link.dqs_t) begin
    wl_cap_ff <= link.ck;
  end

  always_ff @(posedge link.ck) begin
    wl_s1_ff <= wl_cap_ff;
  end

  assign link.dq       = dq_ff;
  assign link.dq_oe    = dq_oe_ff;
  assign hi_current_on = hi_s2_ff;
  assign vref_code     = vref_ff;
  assign vref_settled  = settled_ff;
  assign odt_on        = odt_ff;
endmodule : dtm_dev_end

// ===== rtl/dtm_ctrl_end.sv
`timescale 1ns/10ps
module dtm_ctrl_end (
  dtm_link_if.ctrl                 link,
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ca_start,
  input  wire logic [dtm_pkg::CA_W-1:0] ca_pattern,
  input  wire logic                wl_start,
  output logic                     busy,
  output logic                     done,
  output logic [dtm_pkg::DQ_W-1:0] result
);
  import dtm_pkg::*;

  typedef enum {
    ST_IDLE, ST_CA_PARK, ST_CA_ENTRY, ST_CA_SEL, ST_CA_SELW, ST_CA_STRB, ST_CA_RES,
    ST_CA_HOLD, ST_CA_EXIT, ST_WL_MODE, ST_WL_PRE, ST_WL_EDGE, ST_WL_RES, ST_DONE
  } dtm_ctrl_state_t;

  dtm_ctrl_state_t  state_ff, nxt_state;
  logic             ck_ff, ck_seed_ff, req_ca_ff, req_wl_ff;
  logic             tmr_load, tmr_zero;
  logic [TMR_W-1:0] tmr_val;
  logic [DQ_W-1:0]  dq_s1_ff, dq_s2_ff, result_ff;
  logic [CA_W-1:0]  ca_ff;
  logic             cke_ff, cs_ff, ca_mode_ff, wl_mode_ff, dqs_t_ff, dqs_oe_ff;
  logic             busy_ff, done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // free-running link clock; never stopped, so every valid-clock window holds.
  // it also runs through reset so the device end's synchronised reset sees
  // link edges; the seed only gives the toggle a known start
  always_ff @(posedge clk) begin
    ck_seed_ff <= reset | ck_seed_ff;
  end

  always_ff @(posedge clk) begin
    if (ck_seed_ff) begin
      ck_ff <= ~ck_ff;
    end else begin
      ck_ff <= 1'b0;
    end
  end

  // start pulses may land in either clock phase
  always_ff @(posedge clk) begin
    if (reset) begin
      req_ca_ff <= 1'b0;
      req_wl_ff <= 1'b0;
    end else if (state_ff != ST_IDLE) begin
      req_ca_ff <= 1'b0;
      req_wl_ff <= 1'b0;
    end else begin
      req_ca_ff <= req_ca_ff | ca_start;
      req_wl_ff <= req_wl_ff | (wl_start & ~ca_start);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ca_ff <= '0;
    end else if (state_ff == ST_IDLE && ca_start) begin
      ca_ff <= ca_pattern;
    end
  end

  // result lines are static by the time they are read, so a plain
  // two-stage capture is enough for the whole word
  always_ff @(posedge clk) begin
    dq_s1_ff <= link.dq;
    dq_s2_ff <= dq_s1_ff;
  end

  ////////////////////////////////////////////////////////////////////////////
  dtm_timer u_timer (
    .clk   (clk),
    .reset (reset),
    .load  (tmr_load),
    .value (tmr_val),
    .zero  (tmr_zero)
  );

  // moves only on the edge where the link clock falls, so the device
  // samples settled values on its next rising edge
  always_comb begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_val   = '0;
    if (ck_ff && tmr_zero) begin
      case (state_ff)
        ST_IDLE: begin
          if (req_ca_ff) begin
            nxt_state = ST_CA_PARK;
            tmr_load  = 1'b1;
            tmr_val   = C_STRB_HOLD;
          end else if (req_wl_ff) begin
            nxt_state = ST_WL_MODE;
            tmr_load  = 1'b1;
            tmr_val   = C_WL_EN;
          end
        end
        ST_CA_PARK: begin
          nxt_state = ST_CA_ENTRY;
          tmr_load  = 1'b1;
          tmr_val   = C_ENTRY;
        end
        ST_CA_ENTRY: begin
          nxt_state = ST_CA_SEL;
        end
        ST_CA_SEL: begin
          nxt_state = ST_CA_SELW;
          tmr_load  = 1'b1;
          tmr_val   = C_SEL_STRB;
        end
        ST_CA_SELW: begin
          nxt_state = ST_CA_STRB;
        end
        ST_CA_STRB: begin
          nxt_state = ST_CA_RES;
          tmr_load  = 1'b1;
          tmr_val   = C_CA_RES;
        end
        ST_CA_RES: begin
          nxt_state = ST_CA_HOLD;
          tmr_load  = 1'b1;
          tmr_val   = C_HOLD;
        end
        ST_CA_HOLD: begin
          nxt_state = ST_CA_EXIT;
          tmr_load  = 1'b1;
          tmr_val   = C_STRB_REL;
        end
        ST_CA_EXIT: begin
          nxt_state = ST_DONE;
        end
        ST_WL_MODE: begin
          nxt_state = ST_WL_PRE;
          tmr_load  = 1'b1;
          tmr_val   = C_WL_PRE;
        end
        ST_WL_PRE: begin
          nxt_state = ST_WL_EDGE;
        end
        ST_WL_EDGE: begin
          nxt_state = ST_WL_RES;
          tmr_load  = 1'b1;
          tmr_val   = C_WL_RES;
        end
        ST_WL_RES: begin
          nxt_state = ST_DONE;
        end
        ST_DONE: begin
          nxt_state = ST_IDLE;
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link outputs registered from the next state
  always_ff @(posedge clk) begin
    if (reset) begin
      cke_ff     <= 1'b1;
      cs_ff      <= 1'b0;
      ca_mode_ff <= 1'b0;
      wl_mode_ff <= 1'b0;
      dqs_t_ff   <= 1'b0;
      dqs_oe_ff  <= 1'b0;
    end else begin
      cke_ff     <= !(nxt_state inside {ST_CA_ENTRY, ST_CA_SEL, ST_CA_SELW, ST_CA_STRB,
                                        ST_CA_RES, ST_CA_HOLD});
      cs_ff      <= (nxt_state == ST_CA_SEL);
      ca_mode_ff <= (nxt_state inside {ST_CA_PARK, ST_CA_ENTRY, ST_CA_SEL, ST_CA_SELW,
                                       ST_CA_STRB, ST_CA_RES, ST_CA_HOLD, ST_CA_EXIT});
      wl_mode_ff <= (nxt_state inside {ST_WL_MODE, ST_WL_PRE, ST_WL_EDGE, ST_WL_RES});
      dqs_t_ff   <= (nxt_state inside {ST_CA_STRB, ST_WL_EDGE});
      // strobe parked before entry and held through the exit wait
      dqs_oe_ff  <= (nxt_state inside {ST_CA_PARK, ST_CA_ENTRY, ST_CA_SEL, ST_CA_SELW,
                                       ST_CA_STRB, ST_CA_RES, ST_CA_HOLD, ST_CA_EXIT,
                                       ST_WL_PRE, ST_WL_EDGE});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (reset) begin
      result_ff <= '0;
    end else if (state_ff == ST_CA_RES && nxt_state == ST_CA_HOLD) begin
      result_ff <= dq_s2_ff;
    end else if (state_ff == ST_WL_RES && nxt_state == ST_DONE) begin
      result_ff <= {{(DQ_W-1){1'b0}}, dq_s2_ff[0]};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != ST_IDLE);
      done_ff <= (state_ff == ST_DONE && nxt_state == ST_IDLE);
    end
  end

  assign link.ck      = ck_ff;
  assign link.cke     = cke_ff;
  assign link.cs      = cs_ff;
  assign link.ca      = ca_ff;
  assign link.ca_mode = ca_mode_ff;
  assign link.wl_mode = wl_mode_ff;
  assign link.dqs_t   = dqs_t_ff;
  assign link.dqs_c   = ~dqs_t_ff;
  assign link.dqs_oe  = dqs_oe_ff;
  assign busy         = busy_ff;
  assign done         = done_ff;
  assign result       = result_ff;
endmodule : dtm_ctrl_end

// ===== dv/dtm_link_asserts.sv
`timescale 1ns/10ps
module dtm_link_asserts
  import dtm_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      reset,
  input wire logic                      ck,
  input wire logic                      cke,
  input wire logic                      cs,
  input wire logic [dtm_pkg::CA_W-1:0]  ca,
  input wire logic                      ca_mode,
  input wire logic                      wl_mode,
  input wire logic                      dqs_t,
  input wire logic                      dqs_c,
  input wire logic                      dqs_oe,
  input wire logic [dtm_pkg::DQ_W-1:0]  dq,
  input wire logic                      dq_oe
);
  logic [15:0] wl_cnt_ff;
  logic [15:0] pre_cnt_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  // leveling counts run far past what a repetition may unroll
  always_ff @(posedge clk) begin
    if (reset || !wl_mode) wl_cnt_ff <= 16'h0000;
    else if (wl_cnt_ff != 16'hFFFF) wl_cnt_ff <= wl_cnt_ff + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (reset || !wl_mode || !dqs_oe) pre_cnt_ff <= 16'h0000;
    else if (!dqs_t && pre_cnt_ff != 16'hFFFF) pre_cnt_ff <= pre_cnt_ff + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence no_cmd_s;
    !cs [*8] ##1 !cs [*5];
  endsequence

  sequence quiet_strobe_s;
    !dqs_t [*4];
  endsequence

  ck_toggles_a: assert property (
    !$past(reset) |-> ck != $past(ck)) else $error("link clock stopped");
  strobe_park_a: assert property (
    $fell(cke) |-> $past(dqs_oe && !dqs_t && dqs_c)) else $error("strobe not parked");
  entry_wait_a: assert property (
    $fell(cke) && ca_mode |-> no_cmd_s) else $error("training command too early");
  select_strobe_a: assert property (
    $rose(cs) && ca_mode |-> quiet_strobe_s) else $error("strobe too soon after select");
  cs_hold_a: assert property (
    $fell(cs) && !cke |-> !cke [*8]) else $error("clock-enable high too soon");
  strobe_release_a: assert property (
    $rose(cke) && ca_mode |-> dqs_oe ##1 dqs_oe) else $error("strobe released early");
  dq_hold_a: assert property (
    $rose(cke) && $past(dq_oe) |-> dq_oe) else $error("data released early");
  ca_stable_a: assert property (
    cs && ca_mode |-> $stable(ca)) else $error("pattern moved under select");
  sample_return_a: assert property (
    $rose(cs) && ca_mode |-> ##[1:10] (dq_oe && dq == {{(DQ_W-CA_W){1'b0}}, ca}))
    else $error("training sample not returned");
  wl_drive_a: assert property (
    $rose(dqs_oe) && wl_mode |-> wl_cnt_ff >= 16'h0028) else $error("strobe driven early");
  wl_first_a: assert property (
    $rose(dqs_t) && wl_mode |-> wl_cnt_ff >= 16'h0050) else $error("first strobe early");
  wl_pre_a: assert property (
    $rose(dqs_t) && wl_mode |-> pre_cnt_ff >= 16'h0028) else $error("preamble too short");
endmodule : dtm_link_asserts

// ===== dv/dram_training_mode_timing_tb_top.sv
`timescale 1ns/10ps
module dram_training_mode_timing_tb_top;
  import dtm_pkg::*;
  logic            clk;
  logic            reset;
  logic            ca_start;
  logic            wl_start;
  logic            hi_current_req;
  logic [CA_W-1:0] ca_pattern;
  logic [CA_W-1:0] vref_code;
  logic            busy;
  logic            done;
  logic            hi_current_on;
  logic            vref_settled;
  logic            odt_on;
  logic [DQ_W-1:0] result;
  int              n_errors;
  int              checked;
  int              settle_n;
  int              max_settle;
  int              n;

  dtm_link_if i_dtm_link_if ();
  dtm_ctrl_end i_dtm_ctrl_end (.link(i_dtm_link_if), .clk(clk), .reset(reset),
    .ca_start(ca_start), .ca_pattern(ca_pattern), .wl_start(wl_start), .busy(busy),
    .done(done), .result(result));
  dtm_dev_end i_dtm_dev_end (.link(i_dtm_link_if), .reset(reset),
    .hi_current_req(hi_current_req), .hi_current_on(hi_current_on), .vref_code(vref_code),
    .vref_settled(vref_settled), .odt_on(odt_on));
  dtm_link_asserts i_dtm_link_asserts (.clk(clk), .reset(reset), .ck(i_dtm_link_if.ck),
    .cke(i_dtm_link_if.cke), .cs(i_dtm_link_if.cs), .ca(i_dtm_link_if.ca),
    .ca_mode(i_dtm_link_if.ca_mode), .wl_mode(i_dtm_link_if.wl_mode),
    .dqs_t(i_dtm_link_if.dqs_t), .dqs_c(i_dtm_link_if.dqs_c), .dqs_oe(i_dtm_link_if.dqs_oe),
    .dq(i_dtm_link_if.dq), .dq_oe(i_dtm_link_if.dq_oe));

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // longest stretch with the reference unsettled, in clk cycles
  always @(posedge clk) begin
    if (vref_settled === 1'b0) settle_n++;
    else begin
      if (settle_n > max_settle) max_settle = settle_n;
      settle_n = 0;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_ca(input logic [CA_W-1:0] pat, input int lim);
    max_settle = 0;
    ca_start = 1'b1;
    ca_pattern = pat;
    tick();
    ca_start = 1'b0;
    n = 0;
    while (i_dtm_link_if.cke !== 1'b0 && n < 50) begin
      tick();
      n++;
    end
    // a start while busy must be ignored
    wl_start = 1'b1;
    tick();
    wl_start = 1'b0;
    chk(odt_on, 1'b0);
    while (i_dtm_link_if.cs !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk(odt_on, 1'b1);
    while (done !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    chk(result, {2'b00, pat});
    chk(vref_code, pat);
    chk(max_settle <= lim, 1'b1);
    tick();
    chk({busy, i_dtm_link_if.cke}, 2'b01);
    $display("test ca %0h ended", pat);
  endtask : run_ca

  task automatic run_wl();
    wl_start = 1'b1;
    tick();
    wl_start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    chk({done, result[7:1]}, 8'h80);
    $display("test leveling ended");
  endtask : run_wl

  initial begin
    #400000;
    n_errors++;
    $display("Error at %0t: got %0h expected %0h", $time, 1'b0, 1'b1);
    conclude();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    ca_start = 1'b0;
    wl_start = 1'b0;
    hi_current_req = 1'b0;
    ca_pattern = '0;
    n_errors = 0;
    checked = 0;
    settle_n = 0;
    max_settle = 0;
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    // the device end leaves its synchronised reset two link edges later
    repeat (3) tick();
    chk({busy, done, i_dtm_link_if.cke, vref_settled}, 4'h3);
    // 200 ns on, 100 ns off at 20 ns a cycle
    hi_current_req = 1'b1;
    n = 0;
    while (hi_current_on !== 1'b1 && n < 10) begin
      tick();
      n++;
    end
    chk(hi_current_on, 1'b1);
    hi_current_req = 1'b0;
    n = 0;
    while (hi_current_on !== 1'b0 && n < 5) begin
      tick();
      n++;
    end
    chk(hi_current_on, 1'b0);
    $display("test high current ended");
    // single steps settle in 80 ns, multiple in 240 ns
    run_ca(6'h01, 4);
    run_ca(6'h3F, 12);
    run_ca(6'h3E, 4);
    run_wl();
    run_ca(6'h00, 12);
    run_ca(6'h2A, 12);
    conclude();
  end
endmodule : dram_training_mode_timing_tb_top
